// ### design/cif_filter.sv
// The implementer's own choices: the APB register port and the address map.
`default_nettype none
`include "cif_regs.svh"

module cif_filter
  import cif_pkg::*;
(
  input  wire logic        CLOCK_IN,
  input  wire logic        SRST_IN,
  input  wire logic        CLK_EN_IN,
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [7:0]  PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output logic             PREADY_OUT,
  output logic [31:0]      PRDATA_OUT,
  output logic             PSLVERR_OUT,
  input  wire logic        FRAME_VALID_IN,
  input  wire logic [31:0] FRAME_IDENT_IN,
  input  wire logic        INIT_ACK_IN,
  output logic             INIT_REQ_OUT,
  output logic             FRAME_ACCEPT_OUT,
  output logic [31:0]      FG_IDENT_OUT,
  output logic [2:0]       HIT_INDEX_OUT,
  output logic             IRQ_OUT
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  function automatic logic byte_ok(
    input logic [7:0] id,
    input logic [7:0] code,
    input logic [7:0] mask
  );
    return ((id ^ code) & ~mask) == 8'h00;
  endfunction

  function automatic logic [7:0] filt_hits(
    input logic [31:0] id,
    input cif_bytes_t  c,
    input cif_bytes_t  m,
    input cif_layout_e lay
  );
    logic [3:0][7:0] idr;
    logic            ext;
    logic [7:0]      h;
    h   = 8'h00;
    idr = {id[7:0], id[15:8], id[23:16], id[31:24]};
    ext = id[`CIF_ID_IDE_BIT];
    // Standard frames never look at ident bytes 2 and 3
    unique case (lay)
      CIF_L32: begin
        for (int f = 0; f < 2; f++) begin
          h[f] = byte_ok(idr[0], c[4*f], m[4*f])
               & byte_ok(idr[1], c[4*f+1], m[4*f+1])
               & (!ext
                  | (byte_ok(idr[2], c[4*f+2], m[4*f+2])
                   & byte_ok(idr[3], c[4*f+3], m[4*f+3])));
        end
      end
      CIF_L16: begin
        for (int f = 0; f < 4; f++) begin
          h[f] = byte_ok(idr[0], c[2*f], m[2*f])
               & byte_ok(idr[1], c[2*f+1], m[2*f+1]);
        end
      end
      CIF_L8: begin
        for (int f = 0; f < 8; f++) begin
          h[f] = byte_ok(idr[0], c[f], m[f]);
        end
      end
      CIF_CLOSED: begin
        h = 8'h00;
      end
    endcase
    return h;
  endfunction

  function automatic logic [2:0] first_hit(input logic [7:0] h);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (h[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction

  function automatic cif_reg_e reg_sel(input logic [7:0] a);
    cif_reg_e s;
    s = CIF_REG_NONE;
    if ((a & `CIF_BANK_MASK) == `CIF_OFS_CODE0) begin
      s = CIF_REG_CODE;
    end else if ((a & `CIF_BANK_MASK) == `CIF_OFS_MASK0) begin
      s = CIF_REG_MASK;
    end else if (a == `CIF_OFS_CTRL) begin
      s = CIF_REG_CTRL;
    end else if (a == `CIF_OFS_STAT) begin
      s = CIF_REG_STAT;
    end else if (a == `CIF_OFS_IEN) begin
      s = CIF_REG_IEN;
    end else if (a == `CIF_OFS_FGID) begin
      s = CIF_REG_FGID;
    end
    // Byte lanes of a word other than offset 0 are not decoded
    if (a[1:0] != 2'h0) begin
      s = CIF_REG_NONE;
    end
    return s;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  cif_state_s  q;
  cif_state_s  d;
  cif_reg_e    sel;
  logic [2:0]  idx;
  logic        init_ok;
  logic        wr;
  logic [7:0]  hits;
  logic        any_hit;
  logic [1:0]  w1c;
  logic [1:0]  ev;
  logic [31:0] rd;

  assign sel     = reg_sel(PADDR_IN);
  assign idx     = PADDR_IN[`CIF_IDX_MSB:`CIF_IDX_LSB];
  assign init_ok = q.init_req & INIT_ACK_IN;
  assign wr      = PSEL_IN & PENABLE_IN & PWRITE_IN;
  // Decision uses the buffered copy, never the live input
  assign hits    = filt_hits(q.bg_ident, q.code, q.mask, q.layout);
  assign any_hit = |hits;

  ////////////////////////////////////////////////////////////////////////////
  // Read mux

  always_comb begin
    rd = 32'h0000_0000;
    unique case (sel)
      CIF_REG_CODE: rd[7:0] = q.code[idx];
      CIF_REG_MASK: rd[7:0] = q.mask[idx];
      CIF_REG_CTRL: begin
        rd[`CIF_CTRL_HIT_LSB +: `CIF_HIT_W] = q.hit;
        rd[`CIF_CTRL_LAY_LSB +: `CIF_LAY_W] = q.layout;
        rd[`CIF_CTRL_INIT_BIT]              = q.init_req;
        rd[`CIF_CTRL_ACK_BIT]               = INIT_ACK_IN;
      end
      CIF_REG_STAT: rd[`CIF_EV_W-1:0] = q.stat;
      CIF_REG_IEN:  rd[`CIF_EV_W-1:0] = q.irq_en;
      CIF_REG_FGID: rd = q.fg_ident;
      CIF_REG_NONE: rd = 32'h0000_0000;
      default:      rd = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    d        = q;
    d.accept = 1'b0;
    w1c      = 2'h0;
    ev       = 2'h0;

    // Register writes
    if (wr) begin
      unique case (sel)
        CIF_REG_CODE: begin
          if (init_ok) begin
            d.code[idx] = PWDATA_IN[7:0];
          end
        end
        CIF_REG_MASK: begin
          if (init_ok) begin
            d.mask[idx] = PWDATA_IN[7:0];
          end
        end
        CIF_REG_CTRL: begin
          // Request bit stays writable so init mode can be left
          d.init_req = PWDATA_IN[`CIF_CTRL_INIT_BIT];
          if (init_ok) begin
            d.layout = cif_layout_e'(
              PWDATA_IN[`CIF_CTRL_LAY_LSB +: `CIF_LAY_W]);
          end
        end
        CIF_REG_STAT: w1c = PWDATA_IN[`CIF_EV_W-1:0];
        CIF_REG_IEN:  d.irq_en = PWDATA_IN[`CIF_EV_W-1:0];
        CIF_REG_FGID: d.irq_en = q.irq_en;
        CIF_REG_NONE: d.irq_en = q.irq_en;
        default:      d.irq_en = q.irq_en;
      endcase
    end

    // Filter decision one cycle after capture
    if (q.bg_pend) begin
      d.bg_pend = 1'b0;
      if (any_hit) begin
        d.fg_ident = q.bg_ident;
        d.hit      = first_hit(hits);
        d.accept   = 1'b1;
        ev[`CIF_ST_ACCEPT] = 1'b1;
      end else begin
        ev[`CIF_ST_DROP] = 1'b1;
      end
    end

    // A new frame simply overwrites the background slot
    if (FRAME_VALID_IN) begin
      d.bg_ident = FRAME_IDENT_IN;
      d.bg_pend  = 1'b1;
    end

    // Set wins over clear
    d.stat = (q.stat & ~w1c) | ev;

    // Read data registered in setup so it is steady in access
    if (PSEL_IN & ~PENABLE_IN) begin
      d.rdata = rd;
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      q <= `CIF_RST_STATE;
    end else if (CLK_EN_IN) begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Frozen clock enable also stalls the bus
  // Limitation: a setup edge with clock enable low leaves stale read data
  assign PREADY_OUT       = CLK_EN_IN;
  assign PSLVERR_OUT      = PSEL_IN & PENABLE_IN & (sel == CIF_REG_NONE);
  assign PRDATA_OUT       = q.rdata;
  assign INIT_REQ_OUT     = q.init_req;
  assign FRAME_ACCEPT_OUT = q.accept;
  assign FG_IDENT_OUT     = q.fg_ident;
  assign HIT_INDEX_OUT    = q.hit;
  assign IRQ_OUT          = |(q.stat & q.irq_en);

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge CLOCK_IN);
  endclocking
  default disable iff (SRST_IN);

  AST_BG_CAPTURE: assert property (
    CLK_EN_IN && FRAME_VALID_IN
    |=> q.bg_pend && q.bg_ident == $past(FRAME_IDENT_IN)
  ) else $error("frame not placed in background buffer");

  AST_NOTIFY_PASS: assert property (
    $rose(FRAME_ACCEPT_OUT) |-> $past(q.bg_pend && any_hit)
  ) else $error("accept pulse without a passing frame");

  AST_DROP: assert property (
    CLK_EN_IN && q.bg_pend && !any_hit
    |=> !FRAME_ACCEPT_OUT && $stable(FG_IDENT_OUT)
  ) else $error("failing frame reached foreground");

  AST_EXT32: assert property (
    q.layout == CIF_L32 && q.bg_ident[`CIF_ID_IDE_BIT]
    |-> hits[1] == (((q.bg_ident
          ^ {q.code[4], q.code[5], q.code[6], q.code[7]})
          & ~{q.mask[4], q.mask[5], q.mask[6], q.mask[7]}) == 32'h0)
  ) else $error("extended compare of second bank wrong");

  AST_STD32: assert property (
    q.layout == CIF_L32 && !q.bg_ident[`CIF_ID_IDE_BIT]
    |-> hits[0] == (((q.bg_ident[31:16] ^ {q.code[0], q.code[1]})
          & ~{q.mask[0], q.mask[1]}) == 16'h0)
  ) else $error("standard compare of first bank wrong");

  AST_EXACT: assert property (
    q.layout == CIF_L8 && q.mask[0] == 8'h00
    |-> hits[0] == (q.bg_ident[31:24] == q.code[0])
  ) else $error("unmasked byte compare wrong");

  AST_IGNORE: assert property (
    q.layout == CIF_L8 && q.mask[7] == 8'hff |-> hits[7]
  ) else $error("fully masked filter did not hit");

  AST_CLOSED: assert property (
    CLK_EN_IN && q.layout == CIF_CLOSED |=> !FRAME_ACCEPT_OUT
  ) else $error("closed filter accepted a frame");

  AST_LOCKED: assert property (
    CLK_EN_IN && wr && !init_ok
    |=> q.code == $past(q.code) && q.mask == $past(q.mask)
  ) else $error("filter byte changed outside init mode");

  AST_HIT_UPD: assert property (
    $rose(FRAME_ACCEPT_OUT) && $past(CLK_EN_IN)
    |-> HIT_INDEX_OUT == $past(first_hit(hits))
        && FG_IDENT_OUT == $past(q.bg_ident)
  ) else $error("hit index or foreground not updated");

  AST_HIT_LOW: assert property (
    $rose(FRAME_ACCEPT_OUT) && $past(CLK_EN_IN) && $past(hits[0])
    |-> HIT_INDEX_OUT == 3'h0
  ) else $error("lowest filter not reported");

  AST_L16_BANK: assert property (
    q.layout == CIF_L16
    |-> hits[2] == (((q.bg_ident[31:16] ^ {q.code[4], q.code[5]})
          & ~{q.mask[4], q.mask[5]}) == 16'h0)
  ) else $error("third half-word filter compare wrong");

  AST_L8_BYTE: assert property (
    q.layout == CIF_L8
    |-> hits[5] == (((q.bg_ident[31:24] ^ q.code[5])
          & ~q.mask[5]) == 8'h00)
  ) else $error("byte filter not qualified by its own mask");

  AST_ACCEPT_FLAG: assert property (
    FRAME_ACCEPT_OUT |-> q.stat[`CIF_ST_ACCEPT]
  ) else $error("accept pulse without accept status");

  AST_DROP_IRQ: assert property (
    CLK_EN_IN && !wr && q.bg_pend && !any_hit && q.irq_en[`CIF_ST_DROP]
    |=> IRQ_OUT
  ) else $error("enabled drop event raised no interrupt");

  AST_MISALIGNED: assert property (
    PSEL_IN && PENABLE_IN && PADDR_IN[1:0] != 2'h0 |-> PSLVERR_OUT
  ) else $error("misaligned access not refused");

  AST_LAYOUT_LOCK: assert property (
    CLK_EN_IN && wr && !init_ok
    |=> q.layout == $past(q.layout)
  ) else $error("layout changed outside init mode");

  AST_HIT_HOLD: assert property (
    CLK_EN_IN && !q.bg_pend
    |=> $stable(HIT_INDEX_OUT) && $stable(FG_IDENT_OUT)
  ) else $error("hit index moved without a foreground load");

  AST_PEND_CLEAR: assert property (
    CLK_EN_IN && q.bg_pend && !FRAME_VALID_IN
    |=> !q.bg_pend
  ) else $error("background slot still pending after decision");

  COV_ACCEPT: cover property (
    CLK_EN_IN && q.bg_pend && any_hit ##1 FRAME_ACCEPT_OUT
  );

  COV_DROP: cover property (
    CLK_EN_IN && q.bg_pend && !any_hit
  );

  COV_MULTI: cover property (
    CLK_EN_IN && q.bg_pend && hits[0] && hits[1]
  );

  COV_INIT_WR: cover property (
    CLK_EN_IN && wr && init_ok && sel == CIF_REG_MASK
  );

  COV_EXT: cover property (
    CLK_EN_IN && q.bg_pend && q.layout == CIF_L32 && q.bg_ident[`CIF_ID_IDE_BIT]
  );

endmodule // cif_filter
`default_nettype wire

// ### design/cif_pkg.sv
`default_nettype none
package cif_pkg;

  typedef logic [7:0][7:0] cif_bytes_t;

  typedef enum logic [1:0] {
    CIF_L32    = 2'h0,
    CIF_L16    = 2'h1,
    CIF_L8     = 2'h2,
    CIF_CLOSED = 2'h3
  } cif_layout_e;

  typedef enum logic [2:0] {
    CIF_REG_CODE = 3'h0,
    CIF_REG_MASK = 3'h1,
    CIF_REG_CTRL = 3'h2,
    CIF_REG_STAT = 3'h3,
    CIF_REG_IEN  = 3'h4,
    CIF_REG_FGID = 3'h5,
    CIF_REG_NONE = 3'h6
  } cif_reg_e;

  typedef struct packed {
    cif_bytes_t  code;
    cif_bytes_t  mask;
    cif_layout_e layout;
    logic        init_req;
    logic [2:0]  hit;
    logic [1:0]  stat;
    logic [1:0]  irq_en;
    logic [31:0] bg_ident;
    logic        bg_pend;
    logic [31:0] fg_ident;
    logic        accept;
    logic [31:0] rdata;
  } cif_state_s;

endpackage
`default_nettype wire

// ### design/cif_regs.svh
`ifndef CIF_REGS_SVH
`define CIF_REGS_SVH
// Notes on behaviour
// - Every frame lands in background buffer first
// - Notify processor only for frames that pass; drop events also raise IRQ_OUT when enabled in IEN
// - Failing frame is overwritten by next frame
// - Code bytes compared bitwise with identifier bytes
// - Extended frames use all four bank bytes
// - Standard frames use first two bank bytes
// - Each byte compare qualified by same-index mask
// - Mask bit 0 needs identifier bit equal code
// - Mask bit 1 makes code bit don't care
// - Accept only when all unmasked bits match
// - Readable always, writable only in init mode
// - Layout select: 2x32, 4x16, 8x8 or closed
// - Closed filter accepts nothing, foreground untouched
// - Hit index updated on foreground load

// Register byte offsets
`define CIF_OFS_CODE0   8'h00
`define CIF_OFS_MASK0   8'h20
`define CIF_OFS_CTRL    8'h40
`define CIF_OFS_STAT    8'h44
`define CIF_OFS_IEN     8'h48
`define CIF_OFS_FGID    8'h4c
`define CIF_BANK_MASK   8'he0
`define CIF_IDX_MSB     4
`define CIF_IDX_LSB     2

// Field positions
`define CIF_CTRL_HIT_LSB  0
`define CIF_HIT_W         3
`define CIF_CTRL_LAY_LSB  4
`define CIF_LAY_W         2
`define CIF_CTRL_INIT_BIT 8
`define CIF_CTRL_ACK_BIT  9
`define CIF_EV_W          2
`define CIF_ST_ACCEPT     0
`define CIF_ST_DROP       1
`define CIF_ID_IDE_BIT    19

// Every register resets to zero
`define CIF_RST_STATE     '0

`endif

// ### sim/cif_filter_tb.sv
`default_nettype none
module cif_filter_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk, srst, cen, psel, pen, pwr, fv, ack, pready, perr;
  logic        acc, irq, ireq, rerr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, fid, fgid, rdat;
  logic [2:0]  hit;
  logic [2:0]  lh = 3'h0;
  logic [7:0]  cd[8] = '{8'h10, 8'h21, 8'h32, 8'h43, 8'h54, 8'h6d, 8'h76, 8'h87};
  logic [7:0]  mk[8] = '{8'h00, 8'h07, 8'h00, 8'h0f, 8'h00, 8'h07, 8'h00, 8'hff};
  logic [31:0] ids[$] = '{32'h10213243, 32'h1026ffff, 32'h546d7687, 32'h546d0000,
                          32'h32430000, 32'h11213243, 32'h87000000, 32'h546d76ee};
  logic [34:0] got_q[$], exp_q[$];
  int          failures, comparisons;

  cif_filter u_dut (.CLOCK_IN(clk), .SRST_IN(srst), .CLK_EN_IN(cen), .PSEL_IN(psel),
    .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
    .PREADY_OUT(pready), .PRDATA_OUT(prdata), .PSLVERR_OUT(perr), .FRAME_VALID_IN(fv),
    .FRAME_IDENT_IN(fid), .INIT_ACK_IN(ack), .INIT_REQ_OUT(ireq), .FRAME_ACCEPT_OUT(acc),
    .FG_IDENT_OUT(fgid), .HIT_INDEX_OUT(hit), .IRQ_OUT(irq));
  cif_rx_model u_rx (.clk_in(clk), .init_req_in(ireq), .frame_valid_out(fv),
    .frame_ident_out(fid), .init_ack_out(ack));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Registered outputs read before this edge lands
  always @(posedge clk) begin
    if (acc === 1'b1) begin
      got_q.push_back({hit, fgid});
    end
  end

  task automatic summarize;
    if (failures == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [34:0] got, input logic [34:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Idle edge after each transfer keeps drivers single per step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdat = prdata;
    rerr = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (pready !== 1'b1) begin
      failures++;
      summarize();
    end
    @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [3:0] ref_hit(input logic [31:0] id, input int lay);
    logic [3:0] r;
    logic       ok;
    int         nb, st;
    r = 4'h0;
    nb = (lay == 0) ? (id[19] ? 4 : 2) : (lay == 1 ? 2 : 1);
    st = 8 >> (lay + 1);
    for (int f = (lay < 3 ? (2 << lay) - 1 : -1); f >= 0; f--) begin
      ok = 1'b1;
      for (int j = 0; j < nb; j++)
        if (((id[31-8*j -: 8] ^ cd[f*st+j]) & ~mk[f*st+j]) != 8'h0) ok = 1'b0;
      if (ok) r = {1'b1, 3'(f)};
    end
    return r;
  endfunction

  task automatic setup(input logic [1:0] lay);
    apb(1'b1, 8'h40, 32'h100);
    chk({34'h0, ireq}, 35'h1);
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, 8'(4*i), {24'h0, cd[i]});
      apb(1'b1, 8'(32+4*i), {24'h0, mk[i]});
    end
    apb(1'b1, 8'h40, {23'h0, 1'b1, 2'h0, lay, 4'h0});
    apb(1'b1, 8'h40, {26'h0, lay, 4'h0});
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, 8'(4*i), 32'h0);
      chk({3'h0, rdat}, {27'h0, cd[i]});
      apb(1'b0, 8'(32+4*i), 32'h0);
      chk({3'h0, rdat}, {27'h0, mk[i]});
    end
  endtask

  task automatic run(input int lay);
    logic [3:0] r;
    logic [1:0] st;
    exp_q.delete();
    got_q.delete();
    st = 2'h0;
    foreach (ids[k]) begin
      r = ref_hit(ids[k], lay);
      st |= r[3] ? 2'h1 : 2'h2;
      if (r[3]) begin
        exp_q.push_back({r[2:0], ids[k]});
        lh = r[2:0];
      end
    end
    apb(1'b1, 8'h44, 32'h3);
    u_rx.send(ids);
    repeat (4) @(posedge clk);
    chk(35'(got_q.size()), 35'(exp_q.size()));
    foreach (exp_q[k]) chk(got_q[k], exp_q[k]);
    apb(1'b0, 8'h44, 32'h0);
    chk({3'h0, rdat}, {33'h0, st});
    apb(1'b0, 8'h40, 32'h0);
    chk({3'h0, rdat}, {29'h0, 2'(lay), 1'b0, lh});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    srst = 1'b1;
    cen = 1'b1;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    failures = 0;
    comparisons = 0;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 16; i++) begin
      apb(1'b0, 8'(4*i), 32'h0);
      chk({3'h0, rdat}, 35'h0);
    end
    apb(1'b0, 8'h50, 32'h0);
    chk({2'h0, rerr, rdat}, 35'h100000000);
    // Outside init mode a code write must not land
    apb(1'b1, 8'h00, 32'h5a);
    apb(1'b0, 8'h00, 32'h0);
    chk({3'h0, rdat}, 35'h0);
    for (int lay = 0; lay < 4; lay++) begin
      setup(2'(lay));
      run(lay);
    end
    setup(2'h0);
    apb(1'b1, 8'h44, 32'h3);
    apb(1'b1, 8'h48, 32'h1);
    u_rx.send(ids[0:0]);
    repeat (4) @(posedge clk);
    chk({34'h0, irq}, 35'h1);
    apb(1'b1, 8'h48, 32'h0);
    chk({34'h0, irq}, 35'h0);
    apb(1'b1, 8'h48, 32'h1);
    chk({34'h0, irq}, 35'h1);
    apb(1'b1, 8'h44, 32'h1);
    chk({34'h0, irq}, 35'h0);
    apb(1'b1, 8'h48, 32'h2);
    u_rx.send(ids[3:3]);
    repeat (4) @(posedge clk);
    chk({34'h0, irq}, 35'h1);
    summarize();
  end
endmodule // cif_filter_tb
`default_nettype wire

// ### sim/cif_rx_model.sv
`default_nettype none
module cif_rx_model (
  input  wire logic        clk_in,
  input  wire logic        init_req_in,
  output logic             frame_valid_out,
  output logic [31:0]      frame_ident_out,
  output logic             init_ack_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    frame_valid_out = 1'b0;
    frame_ident_out = 32'h0;
    init_ack_out = 1'b0;
  end

  // Controller grants init mode one cycle late
  always @(posedge clk_in) begin
    init_ack_out <= init_req_in;
  end

  // Frames back to back; caller enters just after an edge
  task automatic send(input logic [31:0] ids[$]);
    foreach (ids[i]) begin
      frame_valid_out <= 1'b1;
      frame_ident_out <= ids[i];
      @(posedge clk_in);
    end
    frame_valid_out <= 1'b0;
    // Stale bus shows inverse, not a lucky copy
    frame_ident_out <= ~ids[ids.size()-1];
  endtask
endmodule // cif_rx_model
`default_nettype wire
